// file: rtl/pstmc_core.sv
// Processor state and privilege-mode controller.
// Assumes synchronous pins and a 200 MHz single clock.
`timescale 1ns/100ps
module pstmc_core (
    input wire logic clk,
    input wire logic nrst,
    input wire logic power_on_reset_n,
    input wire logic manual_reset_n,
    input wire pstmc_pkg::pstmc_exc_t exc_in,
    input wire logic exc_return,
    input wire logic bus_request,
    input wire logic sleep_req,
    input wire pstmc_pkg::pstmc_pd_t pd_mode,
    input wire logic wake_event,
    input wire logic [31:0] vbr_wdata,
    input wire logic vbr_we,
    input wire logic [31:0] bus_cfg_wdata,
    input wire logic bus_cfg_we,
    input wire pstmc_pkg::pstmc_acc_t acc_in,
    output pstmc_pkg::pstmc_state_t state,
    output logic [31:0] pc,
    output logic [31:0] status_word,
    output logic [31:0] saved_program_counter,
    output logic [31:0] saved_status_word,
    output logic [31:0] vbr,
    output logic [31:0] bus_cfg,
    output logic privilege_mode_bit,
    output logic fetch_en,
    output logic bus_granted,
    output logic cpu_halted,
    output pstmc_pkg::pstmc_pd_t pd_active,
    output logic acc_granted,
    output logic acc_refused,
    output logic por_seen
);
    logic por_active;
    logic mrst_active;
    pstmc_pkg::pstmc_state_t state_r, state_nxt;
    logic [31:0] pc_r, pc_nxt;
    logic [31:0] sw_r, sw_nxt;
    logic [31:0] saved_pc_r, saved_pc_nxt;
    logic [31:0] saved_sw_r, saved_sw_nxt;
    logic [31:0] vbr_r, vbr_nxt;
    logic [31:0] bus_cfg_r, bus_cfg_nxt;
    pstmc_pkg::pstmc_pd_t pd_r, pd_nxt;
    logic gr_r, gr_nxt;
    logic rf_r, rf_nxt;
    logic any_reset;

    function automatic logic [31:0] set_md(input logic [31:0] s,
                                           input logic md);
        set_md = md ? (s | pstmc_pkg::MODE_BIT_MASK)
                    : (s & ~pstmc_pkg::MODE_BIT_MASK);
    endfunction

    pstmc_reset_ctl i_pstmc_reset_ctl (
        .clk(clk),
        .nrst(nrst),
        .power_on_reset_n(power_on_reset_n),
        .manual_reset_n(manual_reset_n),
        .por_active(por_active),
        .mrst_active(mrst_active)
    );

    assign any_reset = por_active | mrst_active;

    always_comb begin
        state_nxt = state_r;
        pc_nxt = pc_r;
        sw_nxt = sw_r;
        saved_pc_nxt = saved_pc_r;
        saved_sw_nxt = saved_sw_r;
        vbr_nxt = vbr_r;
        bus_cfg_nxt = bus_cfg_r;
        pd_nxt = pd_r;
        gr_nxt = 1'b0;
        rf_nxt = 1'b0;
        if (bus_cfg_we) begin
            bus_cfg_nxt = bus_cfg_wdata;
        end
        if (por_active) begin
            // Whole-chip init, bus controller included
            state_nxt = pstmc_pkg::PSTMC_RESET;
            sw_nxt = pstmc_pkg::STATUS_RESET;
            vbr_nxt = pstmc_pkg::VBR_RESET;
            saved_pc_nxt = pstmc_pkg::SAVED_RESET;
            saved_sw_nxt = pstmc_pkg::SAVED_RESET;
            bus_cfg_nxt = pstmc_pkg::BUS_CFG_RESET;
            pd_nxt = pstmc_pkg::PSTMC_PD_SLEEP;
            pc_nxt = pstmc_pkg::RESET_VECTOR;
        end else if (mrst_active) begin
            // Refresh keeps running, so bus config survives
            state_nxt = pstmc_pkg::PSTMC_RESET;
            sw_nxt = pstmc_pkg::STATUS_RESET;
            vbr_nxt = pstmc_pkg::VBR_RESET;
            saved_pc_nxt = pstmc_pkg::SAVED_RESET;
            saved_sw_nxt = pstmc_pkg::SAVED_RESET;
            pd_nxt = pstmc_pkg::PSTMC_PD_SLEEP;
            pc_nxt = pstmc_pkg::RESET_VECTOR;
        end else begin
            if (vbr_we && sw_r[pstmc_pkg::MODE_BIT_POS]) begin
                vbr_nxt = vbr_wdata;
            end
            if (acc_in.req) begin
                if (acc_in.priv_only && !sw_r[pstmc_pkg::MODE_BIT_POS]) begin
                    rf_nxt = 1'b1;
                end else begin
                    gr_nxt = 1'b1;
                    if (acc_in.wr && !acc_in.priv_only) begin
                        sw_nxt = {sw_r[31:30], acc_in.wdata[29:0]};
                    end else if (acc_in.wr) begin
                        sw_nxt = acc_in.wdata;
                    end
                end
            end
            case (state_r)
                pstmc_pkg::PSTMC_RESET: begin
                    state_nxt = pstmc_pkg::PSTMC_EXEC;
                    pc_nxt = pstmc_pkg::RESET_VECTOR;
                end
                pstmc_pkg::PSTMC_EXC: begin
                    state_nxt = pstmc_pkg::PSTMC_EXEC;
                end
                pstmc_pkg::PSTMC_EXEC: begin
                    if (exc_in.req) begin
                        // Save and redirect in one edge
                        saved_pc_nxt = exc_in.pc;
                        saved_sw_nxt = sw_r;
                        sw_nxt = set_md(sw_r, 1'b1);
                        pc_nxt = vbr_r + exc_in.offset;
                        state_nxt = pstmc_pkg::PSTMC_EXC;
                    end else if (exc_return) begin
                        pc_nxt = saved_pc_r;
                        sw_nxt = set_md(saved_sw_r, 1'b0);
                    end else if (bus_request) begin
                        state_nxt = pstmc_pkg::PSTMC_BUSREL;
                    end else if (sleep_req) begin
                        pd_nxt = pd_mode;
                        state_nxt = pstmc_pkg::PSTMC_PDOWN;
                    end else begin
                        pc_nxt = pc_r + pstmc_pkg::PC_STEP;
                    end
                end
                pstmc_pkg::PSTMC_BUSREL: begin
                    if (!bus_request) begin
                        state_nxt = pstmc_pkg::PSTMC_EXEC;
                    end
                end
                pstmc_pkg::PSTMC_PDOWN: begin
                    if (exc_in.req) begin
                        saved_pc_nxt = exc_in.pc;
                        saved_sw_nxt = sw_r;
                        sw_nxt = set_md(sw_r, 1'b1);
                        pc_nxt = vbr_r + exc_in.offset;
                        state_nxt = pstmc_pkg::PSTMC_EXC;
                    end else if (wake_event) begin
                        state_nxt = pstmc_pkg::PSTMC_EXEC;
                    end
                end
                default: begin
                    state_nxt = pstmc_pkg::PSTMC_RESET;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= pstmc_pkg::PSTMC_RESET;
            pc_r <= pstmc_pkg::RESET_VECTOR;
            sw_r <= pstmc_pkg::STATUS_RESET;
            saved_pc_r <= pstmc_pkg::SAVED_RESET;
            saved_sw_r <= pstmc_pkg::SAVED_RESET;
            vbr_r <= pstmc_pkg::VBR_RESET;
            bus_cfg_r <= pstmc_pkg::BUS_CFG_RESET;
            pd_r <= pstmc_pkg::PSTMC_PD_SLEEP;
            gr_r <= 1'b0;
            rf_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            pc_r <= pc_nxt;
            sw_r <= sw_nxt;
            saved_pc_r <= saved_pc_nxt;
            saved_sw_r <= saved_sw_nxt;
            vbr_r <= vbr_nxt;
            bus_cfg_r <= bus_cfg_nxt;
            pd_r <= pd_nxt;
            gr_r <= gr_nxt;
            rf_r <= rf_nxt;
        end
    end

    assign state = state_r;
    assign pc = pc_r;
    assign status_word = sw_r;
    assign saved_program_counter = saved_pc_r;
    assign saved_status_word = saved_sw_r;
    assign vbr = vbr_r;
    assign bus_cfg = bus_cfg_r;
    assign privilege_mode_bit = sw_r[pstmc_pkg::MODE_BIT_POS];
    // One-hot bits are flops, so these need no decode
    assign fetch_en = state_r[3];
    assign bus_granted = state_r[2];
    assign cpu_halted = state_r[4];
    assign pd_active = pd_r;
    assign acc_granted = gr_r;
    assign acc_refused = rf_r;
    assign por_seen = por_active;

    sequence s_exc_taken;
        state_r == pstmc_pkg::PSTMC_EXEC && exc_in.req && !any_reset;
    endsequence

    AST_ONEHOT: assert property (@(posedge clk) disable iff (!nrst)
        $onehot(state_r)) else $error("state not one-hot");
    AST_POR: assert property (@(posedge clk) disable iff (!nrst)
        !power_on_reset_n |-> ##2 state_r == pstmc_pkg::PSTMC_RESET)
        else $error("no reset on por");
    AST_MRST: assert property (@(posedge clk) disable iff (!nrst)
        !manual_reset_n |-> ##2 state_r == pstmc_pkg::PSTMC_RESET)
        else $error("no reset on manual");
    AST_BUSCFG_KEEP: assert property (@(posedge clk) disable iff (!nrst)
        mrst_active && !bus_cfg_we |=> $stable(bus_cfg_r))
        else $error("bus config lost");
    AST_BUSCFG_CLR: assert property (@(posedge clk) disable iff (!nrst)
        por_active |=> bus_cfg_r == pstmc_pkg::BUS_CFG_RESET)
        else $error("bus config kept");
    AST_VEC: assert property (@(posedge clk) disable iff (!nrst)
        state_r == pstmc_pkg::PSTMC_RESET && !any_reset
        |=> pc_r == pstmc_pkg::RESET_VECTOR)
        else $error("bad reset vector");
    AST_SAVE: assert property (@(posedge clk) disable iff (!nrst)
        s_exc_taken |=> saved_pc_r == $past(exc_in.pc)
        && saved_sw_r == $past(sw_r)
        && pc_r == $past(vbr_r) + $past(exc_in.offset)
        && state_r == pstmc_pkg::PSTMC_EXC)
        else $error("bad exception entry");
    AST_MDSET: assert property (@(posedge clk) disable iff (!nrst)
        s_exc_taken |=> privilege_mode_bit)
        else $error("mode bit not set");
    AST_MDCLR: assert property (@(posedge clk) disable iff (!nrst)
        state_r == pstmc_pkg::PSTMC_EXEC && exc_return && !exc_in.req
        && !any_reset |=> !privilege_mode_bit)
        else $error("mode bit not cleared");
    AST_REFUSE: assert property (@(posedge clk) disable iff (!nrst)
        acc_in.req && acc_in.priv_only && !privilege_mode_bit && !any_reset
        |=> acc_refused && !acc_granted)
        else $error("user access not refused");
    AST_BUS: assert property (@(posedge clk) disable iff (!nrst)
        state_r == pstmc_pkg::PSTMC_BUSREL && bus_request && !any_reset
        |=> bus_granted) else $error("bus taken back");
    AST_SEQ: assert property (@(posedge clk) disable iff (!nrst)
        state_r == pstmc_pkg::PSTMC_EXEC && !any_reset && !exc_in.req
        && !exc_return && !bus_request && !sleep_req
        |=> pc_r == $past(pc_r) + pstmc_pkg::PC_STEP)
        else $error("pc not sequential");

    AST_PDOWN: assert property (@(posedge clk) disable iff (!nrst)
        state_r == pstmc_pkg::PSTMC_EXEC && sleep_req && !exc_in.req
        && !exc_return && !bus_request && !any_reset
        |=> cpu_halted && pd_r == $past(pd_mode))
        else $error("no power-down entry");

    AST_WAKE: assert property (@(posedge clk) disable iff (!nrst)
        state_r == pstmc_pkg::PSTMC_PDOWN && wake_event && !exc_in.req
        && !any_reset |=> fetch_en)
        else $error("no wake-up");

    // Halted core must not advance its program counter
    AST_HALT_PC: assert property (@(posedge clk) disable iff (!nrst)
        state_r == pstmc_pkg::PSTMC_PDOWN && !exc_in.req && !any_reset
        |=> $stable(pc_r))
        else $error("pc moved while halted");

    AST_GRANT: assert property (@(posedge clk) disable iff (!nrst)
        acc_in.req && !(acc_in.priv_only && !privilege_mode_bit)
        && !any_reset |=> acc_granted && !acc_refused)
        else $error("allowed access refused");

    AST_VBR_KEEP: assert property (@(posedge clk) disable iff (!nrst)
        vbr_we && !privilege_mode_bit && !any_reset |=> $stable(vbr_r))
        else $error("user vector base write");

    AST_RST_MD: assert property (@(posedge clk) disable iff (!nrst)
        any_reset |=> privilege_mode_bit)
        else $error("mode bit clear in reset");

    AST_BOTH_RST: assert property (@(posedge clk) disable iff (!nrst)
        !power_on_reset_n && !manual_reset_n |=> por_seen && !mrst_active)
        else $error("manual reset won");
endmodule

// file: rtl/pstmc_pkg.sv
// Package for processor state and privilege-mode control.
// Assumes a 32-bit address space and one 200 MHz clock.
package pstmc_pkg;
    localparam logic [31:0] RESET_VECTOR = 32'hA0000000;
    localparam int MODE_BIT_POS = 30;
    localparam logic [31:0] STATUS_RESET = 32'h700000F0;
    localparam logic [31:0] MODE_BIT_MASK = 32'h40000000;
    localparam logic [31:0] VBR_RESET = 32'h00000000;
    localparam logic [31:0] BUS_CFG_RESET = 32'h00000000;
    localparam logic [31:0] SAVED_RESET = 32'h00000000;
    // 16-bit instructions
    localparam logic [31:0] PC_STEP = 32'h00000002;

    typedef enum logic [4:0] {
        PSTMC_RESET = 5'h01,
        PSTMC_EXC = 5'h02,
        PSTMC_BUSREL = 5'h04,
        PSTMC_EXEC = 5'h08,
        PSTMC_PDOWN = 5'h10
    } pstmc_state_t;

    typedef enum logic [1:0] {
        PSTMC_PD_SLEEP = 2'h0,
        PSTMC_PD_SWSTBY = 2'h1,
        PSTMC_PD_HWSTBY = 2'h2
    } pstmc_pd_t;

    // Exception request bundle
    typedef struct packed {
        logic req;
        logic [31:0] offset;
        logic [31:0] pc;
    } pstmc_exc_t;

    // Privileged register access request
    typedef struct packed {
        logic req;
        logic priv_only;
        logic wr;
        logic [31:0] wdata;
    } pstmc_acc_t;
endpackage

// file: rtl/pstmc_reset_ctl.sv
// Reset classifier: decides power-on versus manual reset.
// Assumes both reset pins are synchronous to clk.
`timescale 1ns/100ps
module pstmc_reset_ctl (
    input wire logic clk,
    input wire logic nrst,
    input wire logic power_on_reset_n,
    input wire logic manual_reset_n,
    output logic por_active,
    output logic mrst_active
);
    logic por_nxt;
    logic mr_nxt;

    always_comb begin
        por_nxt = ~power_on_reset_n;
        // Power-on wins when both are low
        mr_nxt = ~manual_reset_n & power_on_reset_n;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            por_active <= 1'b1;
            mrst_active <= 1'b0;
        end else begin
            por_active <= por_nxt;
            mrst_active <= mr_nxt;
        end
    end
endmodule

// file: testbench/pstmc_partner.sv
// Partner model: reset pin sources and one external bus requester.
// Assumes the bench calls its tasks just after a falling clock edge.
`timescale 1ns/100ps
module pstmc_partner (
    input wire logic clk,
    output logic power_on_reset_n,
    output logic manual_reset_n,
    output logic bus_request
);
    initial begin
        power_on_reset_n = 1'b1;
        manual_reset_n = 1'b1;
        bus_request = 1'b0;
    end

    // Request is held for the whole ownership, never dropped early
    task automatic own_bus(input int n);
        bus_request = 1'b1;
        repeat (n) @(negedge clk);
        bus_request = 1'b0;
    endtask

    task automatic hold_reset(input logic por, input logic mrst,
                              input int n);
        power_on_reset_n = por;
        manual_reset_n = mrst;
        repeat (n) @(negedge clk);
        power_on_reset_n = 1'b1;
        manual_reset_n = 1'b1;
    endtask
endmodule

// file: testbench/processor_state_mode_control_tb.sv
// Self-checking bench for the processor state and mode controller.
// Assumes inputs change at the falling edge, results settle 1 ns late.
`timescale 1ns/100ps
module processor_state_mode_control_tb;
    typedef struct {int due; int sel; logic [31:0] val;} pstmc_note_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic por_n, mrst_n, bus_request;
    pstmc_pkg::pstmc_exc_t exc_in = '0;
    logic exc_return = 1'b0, sleep_req = 1'b0, wake_event = 1'b0;
    pstmc_pkg::pstmc_pd_t pd_mode = pstmc_pkg::PSTMC_PD_SLEEP;
    logic [31:0] vbr_wdata = 32'h0, bus_cfg_wdata = 32'h0;
    logic vbr_we = 1'b0, bus_cfg_we = 1'b0;
    pstmc_pkg::pstmc_acc_t acc_in = '0;
    pstmc_pkg::pstmc_state_t state;
    pstmc_pkg::pstmc_pd_t pd_active;
    logic [31:0] pc, sw, saved_pc, saved_sw, vbr, bus_cfg;
    logic md, fetch_en, bus_granted, cpu_halted, acc_gr, acc_rf, por_seen;
    logic [31:0] v, off, epc, cfg;
    int cyc = 0, miscompares = 0, n_tests = 0;
    pstmc_note_t q[$];

    always #2.5 clk = ~clk;

    pstmc_partner i_pstmc_partner (.clk(clk), .power_on_reset_n(por_n),
        .manual_reset_n(mrst_n), .bus_request(bus_request));

    pstmc_core i_pstmc_core (.clk(clk), .nrst(nrst),
        .power_on_reset_n(por_n), .manual_reset_n(mrst_n),
        .exc_in(exc_in), .exc_return(exc_return),
        .bus_request(bus_request), .sleep_req(sleep_req),
        .pd_mode(pd_mode), .wake_event(wake_event),
        .vbr_wdata(vbr_wdata), .vbr_we(vbr_we),
        .bus_cfg_wdata(bus_cfg_wdata), .bus_cfg_we(bus_cfg_we),
        .acc_in(acc_in), .state(state), .pc(pc), .status_word(sw),
        .saved_program_counter(saved_pc), .saved_status_word(saved_sw),
        .vbr(vbr), .bus_cfg(bus_cfg), .privilege_mode_bit(md),
        .fetch_en(fetch_en),
        .bus_granted(bus_granted), .cpu_halted(cpu_halted),
        .pd_active(pd_active), .acc_granted(acc_gr),
        .acc_refused(acc_rf), .por_seen(por_seen));

    function automatic logic [31:0] obs(input int sel);
        case (sel)
            0: obs = {27'h0, state};
            1: obs = pc;
            2: obs = sw;
            3: obs = saved_pc;
            4: obs = saved_sw;
            5: obs = vbr;
            6: obs = bus_cfg;
            7: obs = {31'h0, md};
            8: obs = {31'h0, acc_rf};
            9: obs = {31'h0, acc_gr};
            10: obs = {30'h0, pd_active};
            11: obs = {31'h0, bus_granted};
            12: obs = {31'h0, cpu_halted};
            13: obs = {31'h0, por_seen};
            default: obs = {31'h0, fetch_en};
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Note a result due d rising edges from now
    task automatic expect_at(input int d, input int sel,
                             input logic [31:0] val);
        q.push_back('{cyc + d, sel, val});
    endtask

    task automatic print_verdict();
        // Notes never reached count as misses
        miscompares += q.size();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Results taken off the notes as they fall due, oldest first
    always @(posedge clk) begin
        int i;
        cyc++;
        #1;
        i = 0;
        while (i < q.size()) begin
            if (q[i].due == cyc) begin
                check(obs(q[i].sel), q[i].val);
                q.delete(i);
            end else begin
                i++;
            end
        end
    end

    initial begin
        #20000;
        miscompares++;
        print_verdict();
    end

    initial begin
        void'($urandom(32'hA865));
        repeat (4) @(negedge clk);
        expect_at(1, 0, 32'h01);
        expect_at(1, 2, pstmc_pkg::STATUS_RESET);
        expect_at(1, 13, 32'h1);
        @(negedge clk);
        nrst = 1'b1;
        expect_at(2, 0, 32'h08);
        expect_at(2, 14, 32'h1);
        repeat (3) @(negedge clk);
        v = $urandom & 32'hFFFFFF00;
        vbr_wdata = v;
        vbr_we = 1'b1;
        expect_at(1, 5, v);
        @(negedge clk);
        vbr_we = 1'b0;
        off = $urandom & 32'h00000FFE;
        epc = $urandom & 32'hFFFFFFFE;
        exc_in = '{1'b1, off, epc};
        expect_at(1, 0, 32'h02);
        expect_at(1, 3, epc);
        expect_at(1, 4, pstmc_pkg::STATUS_RESET);
        expect_at(1, 1, v + off);
        expect_at(1, 7, 32'h1);
        expect_at(2, 1, v + off);
        expect_at(3, 1, v + off + 32'h2);
        @(negedge clk);
        exc_in = '0;
        repeat (2) @(negedge clk);
        exc_return = 1'b1;
        expect_at(1, 1, epc);
        expect_at(1, 2, pstmc_pkg::STATUS_RESET
            & ~pstmc_pkg::MODE_BIT_MASK);
        expect_at(1, 7, 32'h0);
        @(negedge clk);
        exc_return = 1'b0;
        vbr_wdata = ~v;
        vbr_we = 1'b1;
        acc_in = '{1'b1, 1'b1, 1'b1, $urandom};
        expect_at(1, 8, 32'h1);
        expect_at(1, 9, 32'h0);
        expect_at(2, 5, v);
        @(negedge clk);
        vbr_we = 1'b0;
        acc_in = '{1'b1, 1'b0, 1'b1, $urandom};
        expect_at(1, 9, 32'h1);
        expect_at(1, 7, 32'h0);
        @(negedge clk);
        acc_in = '0;
        expect_at(1, 0, 32'h04);
        expect_at(1, 11, 32'h1);
        expect_at(4, 0, 32'h04);
        expect_at(5, 0, 32'h08);
        i_pstmc_partner.own_bus(4);
        repeat (2) @(negedge clk);
        for (int m = 0; m < 3; m++) begin
            sleep_req = 1'b1;
            pd_mode = pstmc_pkg::pstmc_pd_t'(m);
            expect_at(1, 0, 32'h10);
            expect_at(1, 10, m);
            expect_at(1, 12, 32'h1);
            @(negedge clk);
            sleep_req = 1'b0;
            repeat (2) @(negedge clk);
            wake_event = 1'b1;
            expect_at(1, 0, 32'h08);
            @(negedge clk);
            wake_event = 1'b0;
            @(negedge clk);
        end
        for (int r = 0; r < 3; r++) begin
            cfg = $urandom;
            bus_cfg_wdata = cfg;
            bus_cfg_we = 1'b1;
            expect_at(1, 6, cfg);
            @(negedge clk);
            bus_cfg_we = 1'b0;
            expect_at(3, 0, 32'h01);
            expect_at(3, 1, pstmc_pkg::RESET_VECTOR);
            expect_at(3, 7, 32'h1);
            expect_at(3, 5, pstmc_pkg::VBR_RESET);
            expect_at(3, 13, {31'h0, r != 1});
            expect_at(3, 6, (r == 1) ? cfg
                : pstmc_pkg::BUS_CFG_RESET);
            expect_at(7, 0, 32'h08);
            i_pstmc_partner.hold_reset(r == 1, r == 0, 3);
            repeat (6) @(negedge clk);
        end
        repeat (4) @(negedge clk);
        print_verdict();
    end
endmodule
